// *** design/eeprom_sram_init_i2c.sv ***
// serial eeprom reader that fills an internal sram at reset, then writes
// single bytes back to the eeprom from a small update queue
// assumes the data line is joined open-drain outside and pulled up on board
`default_nettype none

// ==========================================================
// update queue
module upd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = eeprom_init_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign in_ready_o = !((wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]));
  assign out_valid_o = (wr_q != rd_q);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q[PW-1:0]];

  // storage needs no reset, only pointers do
  always_ff @(posedge core_clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q[PW-1:0]] <= in_data_i;
    end
  end

  // pointer update
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : upd_fifo

// ==========================================================
// initializer top
// Operation
// R1: the init output is high from reset until the sequencer enters the stop state.
// R2: an eeprom byte write starts only while init is low and the update request is high.
// R3: the source supplies the eeprom location on update_address and the byte on update_write_data.
// R4: the active-low fetch strobe pulses low while the write address is finishing.
// R5: the source drops the update request unless more address and data are waiting.
// R6: the top level joins data in and out to one open-drain line, pulling low only for a zero.
// R7: the serial clock output goes straight to the eeprom clock with no logic between.
// R8: every eeprom transfer is nine bits, eight data bits then one acknowledge bit.
// R9: the sram address is sized to the sram depth, 256 by default; the word counter has one extra bit in the 16-bit variant.
// R10: the sram write port is eight bits wide in the default configuration.
// R11: in the 16-bit variant each word is two eeprom bytes, upper first, from at least 512 bytes.
// R12: in the 16-bit variant even bytes go to a holding register and odd bytes write the pair.
// R13: a user needing the sram write port puts a mux arbiter in front of this block.
// R14: init issues start with A0, location 00, repeated start with A1, then reads acking all but the last.
// R15: the stop state holds a stop and on a request issues start and loads the A0 command.
// R16: a write sends command (nack back to stop), address, data, then returns to stop.
// R17: the sram write strobe is low during the ack step after each byte read (odd bytes only in the 16-bit variant), addressed by the word counter.
module eeprom_sram_init_i2c #(
  parameter int RAM_DEPTH = eeprom_init_pkg::RAM_DEPTH,
  parameter int RAM_WIDTH = eeprom_init_pkg::RAM_WIDTH,
  parameter int FIFO_DEPTH = eeprom_init_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic update_request_i,
  input wire logic update_push_i,
  output logic update_ready_o,
  input wire logic [7:0] update_address_i,
  input wire logic [7:0] update_write_data_i,
  output logic update_fetch_strobe_n_o,
  output logic init_o,
  output logic serial_clock_o,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_oe_n_o,
  output logic ram_write_strobe_n_o,
  output logic [$clog2(RAM_DEPTH)-1:0] ram_write_address_o,
  output logic [RAM_WIDTH-1:0] ram_write_data_o,
  output logic ram_write_clock_o
);
  localparam int AW = $clog2(RAM_DEPTH);
  localparam bit WIDE = (RAM_WIDTH == 16);
  localparam int CW = AW + (WIDE ? 1 : 0); // counts bytes in the wide variant

  // elaboration checks
  if (RAM_WIDTH != 8 && RAM_WIDTH != 16)
  begin : g_bad_width
    $error("ram width must be 8 or 16");
  end
  if (RAM_DEPTH < 2 || (1 << AW) != RAM_DEPTH)
  begin : g_bad_ram_depth
    $error("ram depth must be a power of two");
  end
  if (eeprom_init_pkg::QUARTER_CYC < 2)
  begin : g_bad_quarter
    $error("quarter step must span at least two core cycles");
  end

  // ==========================================================
  // declarations
  eeprom_init_pkg::seq_state_t state_q;
  eeprom_init_pkg::link_op_t op_q;
  eeprom_init_pkg::upd_entry_t in_entry;
  eeprom_init_pkg::upd_entry_t head;
  logic [$clog2(eeprom_init_pkg::QUARTER_CYC + 1)-1:0] qcnt_q;
  logic tick;
  logic [1:0] step_q;
  logic [3:0] bit_counter_q;
  logic [7:0] tx_byte_q;
  logic [7:0] received_byte_q;
  logic [7:0] wdata_q;
  logic [7:0] hold_q;
  logic [CW-1:0] word_counter_q;
  logic scl_q;
  logic sda_q;
  logic sda_meta_q;
  logic sda_sync_q;
  logic init_q;
  logic head_valid;
  logic rx_mode;
  logic last_byte;
  logic byte_done;
  logic nack_now;
  logic fetch;
  logic drive_bit;
  logic ram_write_indicator;

  // ==========================================================
  // update queue between the source and the link
  assign in_entry.addr = update_address_i; // R3
  assign in_entry.data = update_write_data_i; // R3

  upd_fifo #(
    .WIDTH($bits(eeprom_init_pkg::upd_entry_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(update_push_i),
    .in_ready_o(update_ready_o),
    .in_data_i(in_entry),
    .out_valid_o(head_valid),
    .out_ready_i(fetch),
    .out_data_o(head)
  );

  // ==========================================================
  // quarter-step enable from the core clock
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      qcnt_q <= '0;
    end
    else if (tick)
    begin
      qcnt_q <= ($bits(qcnt_q))'(eeprom_init_pkg::QUARTER_CYC - 1);
    end
    else
    begin
      qcnt_q <= qcnt_q - 1'b1;
    end
  end

  assign tick = (qcnt_q == '0);

  // two-flop synchroniser on the returning data line
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
    end
    else
    begin
      sda_meta_q <= serial_data_in_i;
      sda_sync_q <= sda_meta_q;
    end
  end

  // ==========================================================
  // link decode
  assign rx_mode = (state_q == eeprom_init_pkg::S_READ);
  assign last_byte = (word_counter_q == {CW{1'b1}});
  assign byte_done = tick && (op_q == eeprom_init_pkg::OP_BYTE) &&
                     (step_q == eeprom_init_pkg::STEP_SAMPLE) &&
                     (bit_counter_q == eeprom_init_pkg::BIT_ACK); // R8
  assign nack_now = !rx_mode && sda_sync_q;
  // the pop happens as the last address bit is sampled, so the data is latched in time
  assign fetch = tick && (state_q == eeprom_init_pkg::S_WADDR) && (op_q == eeprom_init_pkg::OP_BYTE) &&
                 (step_q == eeprom_init_pkg::STEP_SAMPLE) &&
                 (bit_counter_q == eeprom_init_pkg::BIT_LAST_DATA);
  assign update_fetch_strobe_n_o = !fetch; // R4

  // bit to place on the line: data, released ack, or our own ack or nack
  always_comb
  begin
    drive_bit = 1'b1;
    if (bit_counter_q != eeprom_init_pkg::BIT_ACK)
    begin
      drive_bit = rx_mode ? 1'b1 : tx_byte_q[3'(eeprom_init_pkg::BIT_LAST_DATA - bit_counter_q)];
    end
    else if (rx_mode)
    begin
      drive_bit = last_byte; // R14
    end
  end

  // ==========================================================
  // link engine and sequencer: four quarter steps per bit
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= eeprom_init_pkg::S_INIT_CMD;
      op_q <= eeprom_init_pkg::OP_START;
      tx_byte_q <= eeprom_init_pkg::CMD_WRITE; // R14
      step_q <= eeprom_init_pkg::STEP_FALL;
      bit_counter_q <= '0;
      received_byte_q <= '0;
      wdata_q <= '0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else if (state_q == eeprom_init_pkg::S_CLEAR)
    begin
      state_q <= eeprom_init_pkg::S_READ; // counter clears in this cycle, never on a tick
    end
    else if (tick && op_q == eeprom_init_pkg::OP_HOLD)
    begin
      // idle with a stop on the line until a queued write may go
      if (!init_q && update_request_i && head_valid) // R2
      begin
        state_q <= eeprom_init_pkg::S_WCMD; // R15
        op_q <= eeprom_init_pkg::OP_START;
        tx_byte_q <= eeprom_init_pkg::CMD_WRITE; // R15
        step_q <= eeprom_init_pkg::STEP_FALL;
      end
    end
    else if (tick)
    begin
      step_q <= step_q + 1'b1;
      case (step_q)
        eeprom_init_pkg::STEP_FALL:
        begin
          scl_q <= 1'b0;
        end
        eeprom_init_pkg::STEP_DRIVE:
        begin
          // data moves only while the clock is low, except the start and stop edges
          case (op_q)
            eeprom_init_pkg::OP_START: sda_q <= 1'b1;
            eeprom_init_pkg::OP_STOP: sda_q <= 1'b0;
            default: sda_q <= drive_bit;
          endcase
        end
        eeprom_init_pkg::STEP_RISE:
        begin
          scl_q <= 1'b1;
        end
        default:
        begin
          if (fetch)
          begin
            wdata_q <= head.data;
          end
          case (op_q)
            eeprom_init_pkg::OP_START:
            begin
              sda_q <= 1'b0;
              op_q <= eeprom_init_pkg::OP_BYTE;
              bit_counter_q <= '0;
            end
            eeprom_init_pkg::OP_STOP:
            begin
              sda_q <= 1'b1;
              op_q <= eeprom_init_pkg::OP_HOLD;
            end
            default:
            begin
              if (bit_counter_q != eeprom_init_pkg::BIT_ACK)
              begin
                bit_counter_q <= bit_counter_q + 1'b1; // R8
                if (rx_mode)
                begin
                  received_byte_q <= {received_byte_q[6:0], sda_sync_q};
                end
              end
              else
              begin
                bit_counter_q <= '0;
                case (state_q)
                  eeprom_init_pkg::S_INIT_CMD, eeprom_init_pkg::S_INIT_LOC, eeprom_init_pkg::S_INIT_RCMD:
                  begin
                    if (nack_now)
                    begin
                      // an absent eeprom makes init retry from the top
                      state_q <= eeprom_init_pkg::S_INIT_CMD;
                      op_q <= eeprom_init_pkg::OP_START;
                      tx_byte_q <= eeprom_init_pkg::CMD_WRITE;
                    end
                    else if (state_q == eeprom_init_pkg::S_INIT_CMD)
                    begin
                      state_q <= eeprom_init_pkg::S_INIT_LOC;
                      tx_byte_q <= eeprom_init_pkg::INIT_LOCATION; // R14
                    end
                    else if (state_q == eeprom_init_pkg::S_INIT_LOC)
                    begin
                      state_q <= eeprom_init_pkg::S_INIT_RCMD;
                      op_q <= eeprom_init_pkg::OP_START; // R14
                      tx_byte_q <= eeprom_init_pkg::CMD_READ;
                    end
                    else
                    begin
                      state_q <= eeprom_init_pkg::S_CLEAR;
                    end
                  end
                  eeprom_init_pkg::S_READ:
                  begin
                    if (last_byte)
                    begin
                      state_q <= eeprom_init_pkg::S_STOP; // R14
                      op_q <= eeprom_init_pkg::OP_STOP;
                    end
                  end
                  eeprom_init_pkg::S_WCMD:
                  begin
                    if (nack_now)
                    begin
                      // eeprom still busy programming: stop and poll again later
                      state_q <= eeprom_init_pkg::S_STOP; // R16
                      op_q <= eeprom_init_pkg::OP_STOP;
                    end
                    else
                    begin
                      state_q <= eeprom_init_pkg::S_WADDR;
                      tx_byte_q <= head.addr; // R16
                    end
                  end
                  eeprom_init_pkg::S_WADDR:
                  begin
                    if (nack_now)
                    begin
                      state_q <= eeprom_init_pkg::S_STOP;
                      op_q <= eeprom_init_pkg::OP_STOP;
                    end
                    else
                    begin
                      state_q <= eeprom_init_pkg::S_WDATA;
                      tx_byte_q <= wdata_q; // R16
                    end
                  end
                  default:
                  begin
                    state_q <= eeprom_init_pkg::S_STOP; // R16
                    op_q <= eeprom_init_pkg::OP_STOP;
                  end
                endcase
              end
            end
          endcase
        end
      endcase
    end
  end

  // ==========================================================
  // init status
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      init_q <= 1'b1;
    end
    else if (state_q == eeprom_init_pkg::S_STOP)
    begin
      init_q <= 1'b0; // R1
    end
  end

  // word counter and wide-variant holding register
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      word_counter_q <= '0;
      hold_q <= '0;
    end
    else if (state_q == eeprom_init_pkg::S_CLEAR)
    begin
      word_counter_q <= '0;
    end
    else if (byte_done && rx_mode)
    begin
      word_counter_q <= word_counter_q + 1'b1; // R9
      if (WIDE && !word_counter_q[0])
      begin
        hold_q <= received_byte_q; // R12
      end
    end
  end

  // ==========================================================
  // sram write port
  // strobe spans the whole ack bit; in the wide variant only odd bytes write
  assign ram_write_indicator = rx_mode && (op_q == eeprom_init_pkg::OP_BYTE) &&
                               (bit_counter_q == eeprom_init_pkg::BIT_ACK) &&
                               (!WIDE || word_counter_q[0]); // R12
  assign ram_write_strobe_n_o = !ram_write_indicator; // R17
  assign ram_write_address_o = word_counter_q[CW-1 -: AW]; // R9

  if (WIDE)
  begin : g_wide
    assign ram_write_data_o = {hold_q, received_byte_q}; // R11
  end
  else
  begin : g_narrow
    assign ram_write_data_o = received_byte_q; // R10
  end

  // the sram writes on its rising edge, as the serial clock falls
  assign ram_write_clock_o = !scl_q;

  // serial pins: the clock leaves untouched, the data pin is open-drain
  assign serial_clock_o = scl_q; // R7
  assign serial_data_out_o = sda_q;
  assign serial_data_oe_n_o = sda_q;
  assign init_o = init_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_init_ends_stop: assert property ($fell(init_o) |-> $past(state_q) == eeprom_init_pkg::S_STOP) // R1
    else $error("init dropped outside the stop state");
  a_write_gate: assert property ((state_q == eeprom_init_pkg::S_STOP) ##1 (state_q == eeprom_init_pkg::S_WCMD)
    |-> $past(update_request_i) && !$past(init_o) && tx_byte_q == eeprom_init_pkg::CMD_WRITE) // R2
    else $error("write began without request or before init ended");
  a_fetch_in_addr: assert property (!update_fetch_strobe_n_o |-> state_q == eeprom_init_pkg::S_WADDR &&
    bit_counter_q == eeprom_init_pkg::BIT_LAST_DATA ##1 update_fetch_strobe_n_o) // R4
    else $error("fetch strobe outside the address byte or too long");
  a_data_clock_low: assert property ($past(op_q) == eeprom_init_pkg::OP_BYTE && $changed(sda_q) |-> !scl_q) // R8
    else $error("data moved while the serial clock was high");
  a_nine_bits: assert property (byte_done |-> bit_counter_q == eeprom_init_pkg::BIT_ACK ##1 bit_counter_q == 4'h0) // R8
    else $error("byte unit was not nine bits");
  a_ram_strobe_ack: assert property ($fell(ram_write_strobe_n_o) |-> scl_q && rx_mode
    ##1 !ram_write_strobe_n_o [*7] ##1 ram_write_strobe_n_o) // R17
    else $error("sram strobe not aligned to a full ack bit");
  a_ram_addr: assert property (!ram_write_strobe_n_o && !$past(ram_write_strobe_n_o)
    |-> $stable(ram_write_address_o) && $stable(ram_write_data_o)) // R9
    else $error("sram address or data moved while the strobe was low");
  a_wide_odd: assert property (!ram_write_strobe_n_o |-> !WIDE || word_counter_q[0]) // R12
    else $error("wide variant wrote on an even byte");
  a_last_nack: assert property (rx_mode && last_byte && bit_counter_q == eeprom_init_pkg::BIT_ACK &&
    step_q == eeprom_init_pkg::STEP_RISE |-> sda_q) // R14
    else $error("last init byte was acknowledged");
  a_write_returns: assert property (byte_done && state_q == eeprom_init_pkg::S_WDATA
    |=> state_q == eeprom_init_pkg::S_STOP && op_q == eeprom_init_pkg::OP_STOP) // R16
    else $error("write did not return to stop");

  c_init_done: cover property ($fell(init_o));
  c_write_done: cover property (byte_done && state_q == eeprom_init_pkg::S_WDATA);
  c_busy_nack: cover property (byte_done && state_q == eeprom_init_pkg::S_WCMD && nack_now);
  c_queue_full: cover property (!update_ready_o);
endmodule : eeprom_sram_init_i2c

`default_nettype wire

// *** design/eeprom_init_pkg.sv ***
// shared constants, types and encodings for the eeprom-to-sram initializer
// assumes a single 10 MHz core clock and an open-drain data line built outside
`default_nettype none

package eeprom_init_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 800;
  // one serial clock period is split into four quarter steps
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // ==========================================================
  // serial protocol values
  localparam logic [7:0] CMD_WRITE = 8'hA0;
  localparam logic [7:0] CMD_READ = 8'hA1;
  localparam logic [7:0] INIT_LOCATION = 8'h00;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] STEP_FALL = 2'h0;
  localparam logic [1:0] STEP_DRIVE = 2'h1;
  localparam logic [1:0] STEP_RISE = 2'h2;
  localparam logic [1:0] STEP_SAMPLE = 2'h3;

  // ==========================================================
  // default sizes
  localparam int RAM_DEPTH = 256;
  localparam int RAM_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    S_INIT_CMD, S_INIT_LOC, S_INIT_RCMD, S_CLEAR, S_READ,
    S_STOP, S_WCMD, S_WADDR, S_WDATA
  } seq_state_t;

  typedef enum logic [1:0] {OP_START, OP_BYTE, OP_STOP, OP_HOLD} link_op_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } upd_entry_t;

endpackage : eeprom_init_pkg

`default_nettype wire

// *** tb/eeprom_model.sv ***
// behavioural two-wire serial eeprom: 256 bytes, byte write, current-address reads
// assumes the bench resolves the data line with a pull-up and feeds it back here
`default_nettype none

// ==========================================================
// eeprom model
module eeprom_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nack_i,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr = 8'h00;
  logic ok;
  int bits = 0;
  int phase = 4; // 0 command, 1 location, 2 write data, 3 reading, 4 idle

  // known contents so every sram word can be predicted
  initial
  begin
    sda_low_o = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  end

  // start: data falls while the clock is high
  always @(negedge sda_i)
  begin
    if (scl_i)
    begin
      phase = 0;
      bits = 0;
    end
  end

  // stop: data rises while the clock is high
  always @(posedge sda_i)
  begin
    if (scl_i)
      phase = 4;
  end

  // shift in on the rising clock; a high ack from the master ends a read
  always @(posedge scl_i)
  begin
    if (bits < 8)
      sh = {sh[6:0], sda_i};
    else if (phase == 3 && sda_i)
      phase = 4;
    bits++;
  end

  // drive only after the falling clock, so data never moves under a high clock
  always @(negedge scl_i)
  begin
    sda_low_o = 1'b0;
    if (bits == 9)
      bits = 0;
    if (bits == 8 && phase < 3)
    begin
      ok = (phase != 0) || (!nack_i && sh[7:1] == 7'h50);
      if (phase == 1)
        ptr = sh;
      if (phase == 2)
        mem[ptr] = sh;
      phase = !ok || phase == 2 ? 4 : phase == 1 ? 2 : sh[0] ? 3 : 1;
      sda_low_o = ok;
    end
    else if (phase == 3)
    begin
      if (bits < 8)
        sda_low_o = !mem[ptr][7 - bits];
      else
        ptr++;
    end
  end
endmodule : eeprom_model

`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the eeprom-to-sram initializer
// assumes the eeprom model is compiled first; sram depth shrunk to 16 words
`default_nettype none

// ==========================================================
// bench top
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEPTH = 16;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic update_request_i = 1'b0;
  logic update_push_i = 1'b0;
  logic [7:0] update_address_i = 8'h00;
  logic [7:0] update_write_data_i = 8'h00;
  logic nack = 1'b0;
  logic update_ready_o, update_fetch_strobe_n_o, init_o, serial_clock_o;
  logic serial_data_oe_n_o, ram_write_strobe_n_o, sda_low, sda_line, sda_out, ram_clk;
  logic [3:0] ram_write_address_o;
  logic [7:0] ram_write_data_o;
  logic [7:0] seen_ram [DEPTH];
  logic strobe_q = 1'b1;
  int wr_cnt = 0;
  int fetch_cnt = 0;
  int bad_count = 0;
  int total_checks = 0;

  always #50 core_clk_i = ~core_clk_i;
  // open-drain line with board pull-up: either party may pull it low
  assign sda_line = (!sda_out || sda_low) ? 1'b0 : 1'b1;

  eeprom_sram_init_i2c #(.RAM_DEPTH(DEPTH)) i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .update_request_i(update_request_i), .update_push_i(update_push_i), .update_ready_o(update_ready_o),
    .update_address_i(update_address_i), .update_write_data_i(update_write_data_i),
    .update_fetch_strobe_n_o(update_fetch_strobe_n_o), .init_o(init_o), .serial_clock_o(serial_clock_o),
    .serial_data_in_i(sda_line), .serial_data_out_o(sda_out), .serial_data_oe_n_o(serial_data_oe_n_o),
    .ram_write_strobe_n_o(ram_write_strobe_n_o), .ram_write_address_o(ram_write_address_o),
    .ram_write_data_o(ram_write_data_o), .ram_write_clock_o(ram_clk));
  eeprom_model i_mem (.scl_i(serial_clock_o), .sda_i(sda_line), .nack_i(nack), .sda_low_o(sda_low));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // init must still be high at each strobe fall; a fetch must land in the location byte
  always @(posedge core_clk_i)
  begin
    strobe_q <= ram_write_strobe_n_o;
    if (!ram_write_strobe_n_o && strobe_q)
      check(init_o, 1'b1);
    if (serial_data_oe_n_o !== sda_out)
      check(serial_data_oe_n_o, sda_out);
    if (update_fetch_strobe_n_o === 1'b0)
    begin
      fetch_cnt <= fetch_cnt + 1;
      check(i_mem.phase, 1);
    end
  end

  // sram stand-in: writes on the rising write clock while the strobe is low
  // the bench is the only writer, so no arbiter sits in front of the write port
  always @(posedge ram_clk)
  begin
    if (ram_write_strobe_n_o === 1'b0)
    begin
      wr_cnt <= wr_cnt + 1;
      seen_ram[ram_write_address_o] <= ram_write_data_o;
    end
  end

  // ==========================================================
  // scenarios
  task automatic t_reset;
    check({init_o, ram_write_strobe_n_o, update_fetch_strobe_n_o, update_ready_o}, 4'hF);
    check({serial_clock_o, serial_data_oe_n_o, sda_out}, 3'h7);
    $display("test reset done");
  endtask : t_reset

  task automatic t_init;
    for (int i = 0; i < 4000 && init_o !== 1'b0; i++) @(posedge core_clk_i);
    #1 check(wr_cnt, DEPTH);
    check(i_mem.phase, 4);
    for (int a = 0; a < DEPTH; a++) check(seen_ram[a], 8'(a) ^ 8'h5A);
    $display("test init done");
  endtask : t_init

  // fill the queue past full while the request stays low, then drain it
  task automatic t_fill;
    @(posedge core_clk_i);
    for (int i = 0; i < 9; i++)
    begin
      update_address_i <= 8'h80 + 8'(i);
      update_write_data_i <= 8'hC0 + 8'(i);
      update_push_i <= 1'b1;
      @(posedge core_clk_i);
    end
    update_push_i <= 1'b0;
    #1 check(update_ready_o, 1'b0);
    repeat (400) @(posedge core_clk_i);
    #1 check({fetch_cnt[3:0], init_o, serial_clock_o, serial_data_oe_n_o}, 7'h03);
    update_request_i <= 1'b1;
    for (int i = 0; i < 5000 && i_mem.mem[8'h87] !== 8'hC7; i++) @(posedge core_clk_i);
    update_request_i <= 1'b0;
    #1 check(fetch_cnt, 8);
    for (int i = 0; i < 9; i++) check(i_mem.mem[8'h80 + i], i < 8 ? 8'hC0 + 8'(i) : 8'h88 ^ 8'h5A);
    check(update_ready_o, 1'b1);
    $display("test fill done");
  endtask : t_fill

  // refused command keeps the entry, which goes out once the eeprom answers again
  task automatic t_nack;
    @(posedge core_clk_i);
    nack <= 1'b1;
    update_address_i <= 8'h30;
    update_write_data_i <= 8'hE1;
    update_push_i <= 1'b1;
    @(posedge core_clk_i);
    update_push_i <= 1'b0;
    update_request_i <= 1'b1;
    repeat (600) @(posedge core_clk_i);
    #1 check({fetch_cnt[3:0], i_mem.mem[8'h30]}, {4'h8, 8'h30 ^ 8'h5A});
    @(posedge core_clk_i);
    nack <= 1'b0;
    for (int i = 0; i < 2000 && i_mem.mem[8'h30] !== 8'hE1; i++) @(posedge core_clk_i);
    update_request_i <= 1'b0;
    #1 check(fetch_cnt, 9);
    check(i_mem.mem[8'h30], 8'hE1);
    $display("test nack done");
  endtask : t_nack

  task automatic results;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    #1 t_reset();
    t_init();
    t_fill();
    t_nack();
    results();
  end

  // watchdog: the run needs under 6k cycles, allow 20k
  initial
  begin
    #2000000;
    bad_count++;
    results();
  end
endmodule : tb

`default_nettype wire
